// ### logic/tws_pkg.sv
// package: register map, field layouts, states and bus events of the two-wire block
package tws_pkg;
   // register indices on the plain register port
   localparam logic [3:0] CTRL_IDX = 4'h0;
   localparam logic [3:0] STAT_IDX = 4'h1;
   localparam logic [3:0] MASK_IDX = 4'h2;
   localparam logic [3:0] TXB_IDX = 4'h3;
   localparam logic [3:0] RXB_IDX = 4'h4;
   localparam logic [3:0] SADR_IDX = 4'h5;
   localparam logic [3:0] BRG_IDX = 4'h6;
   localparam logic [3:0] IFL_IDX = 4'h7;
   localparam logic [3:0] IMSK_IDX = 4'h8;
   // reset values
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] STAT_RST = 16'h0000;
   localparam logic [9:0] MASK_RST = 10'h000;
   localparam logic [9:0] SADR_RST = 10'h050;
   localparam logic [7:0] BRG_RST = 8'h0F;
   // interrupt event bits
   localparam int EV_SEQ = 0;
   localparam int EV_SLV = 1;
   localparam int EV_STOP = 2;
   localparam int EV_W = 3;
   // bit timing: four quarter phases per bus bit
   localparam logic [1:0] PH_LAST = 2'h3;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_LAST = 4'h7;
   // control register layout
   typedef struct packed {
      logic enable;
      logic [8:0] rsvd;
      logic ack_value;
      logic ack_seq_enable;
      logic receive_byte_enable;
      logic stop_seq_enable;
      logic restart_seq_enable;
      logic start_seq_enable;
   } tws_ctrl_type;
   // status register layout
   typedef struct packed {
      logic ack_received_status;
      logic master_busy;
      logic [7:0] rsvd;
      logic data_addr;
      logic stop_seen;
      logic start_seen;
      logic slave_read;
      logic rx_full_flag;
      logic tx_full_flag;
   } tws_stat_type;
   // synchronised line levels and detected bus events
   typedef struct packed {
      logic scl;
      logic sda;
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } tws_bus_type;
   typedef enum logic [2:0] {
      M_IDLE, M_START, M_RESTART, M_STOP, M_TX, M_RX, M_ACK
   } tws_mst_type;
   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_RXD, S_TXD, S_ACKO, S_ACKI
   } tws_slv_type;
endpackage

// ### logic/tws_cond_det.sv
// line synchronisers and start, stop and clock edge detection
module tws_cond_det
   import tws_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic srst, // synchronous reset
   input wire logic scl_in, // clock line level
   input wire logic sda_in, // data line level
   output tws_bus_type bus // synced levels and events
);
   // index 0 is the clock line, index 1 the data line
   logic [1:0] m1_q, m1_d, m2_q, m2_d, p_q, p_d;

   ////////////////////////////////////////////////////////////////////
   // two flops per line, then one more stage for edge detection
   always_comb begin
      m1_d = {sda_in, scl_in};
      m2_d = m1_q;
      p_d = m2_q;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         m1_q <= 2'h3;
         m2_q <= 2'h3;
         p_q <= 2'h3;
      end else begin
         m1_q <= m1_d;
         m2_q <= m2_d;
         p_q <= p_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // a data edge while the clock stays high is a bus condition
   always_comb begin
      bus.scl = m2_q[0];
      bus.sda = m2_q[1];
      bus.scl_rise = m2_q[0] & ~p_q[0];
      bus.scl_fall = ~m2_q[0] & p_q[0];
      bus.start = m2_q[0] & p_q[0] & p_q[1] & ~m2_q[1];
      bus.stop = m2_q[0] & p_q[0] & ~p_q[1] & m2_q[1];
   end
endmodule // tws_cond_det

// ### logic/tws_core.sv
// two-wire master sequencer, slave engine, status and register file
// Behaviour
// RULE_01 - ack value picks ACK or NACK level
// RULE_02 - ack enable sends ack, cleared when done
// RULE_03 - receive enable takes one byte, then clears
// RULE_04 - stop enable makes stop, then clears
// RULE_05 - restart enable makes repeated start, then clears
// RULE_06 - start enable makes start, then clears
// RULE_07 - slave never stretches the clock
// RULE_08 - data/address flag tracks last byte kind
// RULE_09 - stop flag set when stop seen last
// RULE_10 - start flag set when start seen last
// RULE_11 - direction flag updated after each address
// RULE_12 - receive full sets on byte, clears on read
// RULE_13 - transmit full sets on write, clears when sent
// RULE_14 - ack status updated only while transmitting
// RULE_15 - mask bits exempt address bits from compare
// RULE_16 - upper six mask bits read zero
// RULE_17 - software issues one sequence at a time
module tws_core
   import tws_pkg::*;
(
   input wire logic clk, // 50 MHz system clock
   input wire logic srst, // synchronous reset
   input wire logic [3:0] addr, // register index
   input wire logic [15:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [15:0] rdata, // read data, cycle after rd
   output logic irq, // level interrupt
   input wire logic scl_in, // serial_clock_line level
   output logic scl_out, // clock line drive value
   output logic scl_oe, // high while pulling clock low
   input wire logic sda_in, // serial_data_line level
   output logic sda_out, // data line drive value
   output logic sda_oe // high while pulling data low
);
   function automatic logic acc(logic s, logic [3:0] a, logic [3:0] i);
      return s && (a == i);
   endfunction

   tws_bus_type bus;
   tws_ctrl_type ctrl_q, ctrl_d;
   tws_stat_type stat_q, stat_d;
   logic [9:0] amask_q, amask_d, sadr_q, sadr_d;
   logic [7:0] txb_q, txb_d, rxb_q, rxb_d, brg_q, brg_d;
   logic [EV_W-1:0] ifl_q, ifl_d, imsk_q, imsk_d, ev;
   logic [15:0] rdata_q, rdata_d;
   // master state
   tws_mst_type m_st_q, m_st_d;
   logic [1:0] ph_q, ph_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] cnt_q, cnt_d, sh_q, sh_d;
   logic m_scl_lo_q, m_scl_lo_d, m_sda_lo_q, m_sda_lo_d;
   logic mown_q, mown_d, tick;
   logic [4:0] m_clr;
   logic m_done, m_rxv, m_ackv, m_txd;
   // slave state
   tws_slv_type s_st_q, s_st_d;
   logic [3:0] s_cnt_q, s_cnt_d;
   logic [7:0] s_sh_q, s_sh_d;
   logic s_sda_lo_q, s_sda_lo_d;
   logic s_match, s_rxv, s_ackv, s_hit;
   logic txw, rxr;

   tws_cond_det u_det (
      .clk(clk),
      .srst(srst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .bus(bus)
   );

   ////////////////////////////////////////////////////////////////////
   // pins: open drain, drive value is always low
   assign scl_out = 1'h0;
   assign sda_out = 1'h0;
   assign scl_oe = m_scl_lo_q; // RULE_07
   assign sda_oe = m_sda_lo_q | s_sda_lo_q;
   assign rdata = rdata_q;
   assign irq = |(ifl_q & imsk_q);
   assign txw = acc(wr, addr, TXB_IDX);
   assign rxr = acc(rd, addr, RXB_IDX);
   // masked bits drop out of the compare; the received address fills bits 6:0, bits 9:7 compare against zero
   assign s_hit = ((({3'h0, s_sh_q[7:1]} ^ sadr_q) & ~amask_q) == '0); // RULE_15

   ////////////////////////////////////////////////////////////////////
   // register file; hardware sets win over software clears
   always_comb begin
      ctrl_d = ctrl_q;
      stat_d = stat_q;
      amask_d = amask_q;
      sadr_d = sadr_q;
      txb_d = txb_q;
      rxb_d = rxb_q;
      brg_d = brg_q;
      imsk_d = imsk_q;
      rdata_d = '0;
      ev = '0;
      if (acc(wr, addr, CTRL_IDX)) begin
         ctrl_d = tws_ctrl_type'(wdata);
         ctrl_d.rsvd = '0;
      end
      ctrl_d[4:0] = ctrl_d[4:0] & ~m_clr; // RULE_02 RULE_03 RULE_04 RULE_05 RULE_06
      if (acc(wr, addr, MASK_IDX))
         amask_d = wdata[9:0];
      if (acc(wr, addr, SADR_IDX))
         sadr_d = wdata[9:0];
      if (acc(wr, addr, BRG_IDX))
         brg_d = wdata[7:0];
      if (acc(wr, addr, IMSK_IDX))
         imsk_d = wdata[EV_W-1:0];
      if (txw)
         txb_d = wdata[7:0];
      if (m_rxv)
         rxb_d = sh_d;
      if (s_rxv)
         rxb_d = s_sh_q;
      stat_d.rx_full_flag = (stat_q.rx_full_flag & ~rxr) | m_rxv | s_rxv; // RULE_12
      stat_d.tx_full_flag = (stat_q.tx_full_flag & ~(m_txd | s_ackv))
         | txw; // RULE_13
      if (s_match) begin
         stat_d.data_addr = 1'h0; // RULE_08
         stat_d.slave_read = s_sh_q[0]; // RULE_11
      end
      if (txw | s_rxv)
         stat_d.data_addr = 1'h1; // RULE_08
      if (bus.start) begin
         stat_d.start_seen = 1'h1; // RULE_10
         stat_d.stop_seen = 1'h0; // RULE_09
      end
      if (bus.stop) begin
         stat_d.start_seen = 1'h0; // RULE_10
         stat_d.stop_seen = 1'h1; // RULE_09
      end
      // only a transmitted byte's ninth bit updates this
      if (m_ackv | s_ackv)
         stat_d.ack_received_status = bus.sda; // RULE_14
      stat_d.master_busy = mown_d | (m_st_d != M_IDLE);
      ev[EV_SEQ] = m_done;
      ev[EV_SLV] = s_match | s_rxv;
      ev[EV_STOP] = bus.stop;
      ifl_d = ifl_q;
      if (acc(wr, addr, IFL_IDX))
         ifl_d = ifl_q & ~wdata[EV_W-1:0];
      ifl_d = ifl_d | ev;
      if (rd) begin
         case (addr)
            CTRL_IDX: rdata_d = ctrl_q;
            STAT_IDX: rdata_d = stat_q;
            MASK_IDX: rdata_d = {6'h00, amask_q}; // RULE_16
            TXB_IDX: rdata_d = {8'h00, txb_q};
            RXB_IDX: rdata_d = {8'h00, rxb_q};
            SADR_IDX: rdata_d = {6'h00, sadr_q};
            BRG_IDX: rdata_d = {8'h00, brg_q};
            IFL_IDX: rdata_d = {13'h0000, ifl_q};
            IMSK_IDX: rdata_d = {13'h0000, imsk_q};
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_q <= tws_ctrl_type'(CTRL_RST);
         stat_q <= tws_stat_type'(STAT_RST);
         amask_q <= MASK_RST;
         sadr_q <= SADR_RST;
         txb_q <= '0;
         rxb_q <= '0;
         brg_q <= BRG_RST;
         ifl_q <= '0;
         imsk_q <= '0;
         rdata_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         stat_q <= stat_d;
         amask_q <= amask_d;
         sadr_q <= sadr_d;
         txb_q <= txb_d;
         rxb_q <= rxb_d;
         brg_q <= brg_d;
         ifl_q <= ifl_d;
         imsk_q <= imsk_d;
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // master: quarter-bit ticks; one enable served at a time, start first.
   // no clock stretching by peers is honoured, so peers must keep pace
   always_comb begin
      m_st_d = m_st_q;
      ph_d = ph_q;
      bit_d = bit_q;
      sh_d = sh_q;
      m_scl_lo_d = m_scl_lo_q;
      m_sda_lo_d = m_sda_lo_q;
      mown_d = mown_q;
      m_clr = '0;
      m_done = 1'h0;
      m_rxv = 1'h0;
      m_ackv = 1'h0;
      m_txd = 1'h0;
      tick = (cnt_q == '0);
      cnt_d = tick ? brg_q : cnt_q - 8'h01;
      if (m_st_q == M_IDLE) begin
         ph_d = '0;
         bit_d = '0;
         if (ctrl_q.enable && ctrl_q.start_seq_enable)
            m_st_d = M_START;
         else if (ctrl_q.enable && ctrl_q.restart_seq_enable)
            m_st_d = M_RESTART;
         else if (ctrl_q.enable && ctrl_q.stop_seq_enable)
            m_st_d = M_STOP;
         else if (ctrl_q.enable && ctrl_q.receive_byte_enable)
            m_st_d = M_RX;
         else if (ctrl_q.enable && ctrl_q.ack_seq_enable)
            m_st_d = M_ACK;
         else if (ctrl_q.enable && mown_q && stat_q.tx_full_flag) begin
            m_st_d = M_TX;
            sh_d = txb_q;
         end
      end else if (tick) begin
         ph_d = ph_q + 2'h1;
         case (m_st_q)
            M_START: begin
               if (ph_q == 2'h0)
                  m_sda_lo_d = 1'h1; // RULE_06
               if (ph_q == 2'h2)
                  m_scl_lo_d = 1'h1;
               if (ph_q == PH_LAST) begin
                  m_clr[0] = 1'h1; // RULE_06
                  mown_d = 1'h1;
               end
            end
            M_RESTART: begin
               if (ph_q == 2'h0)
                  m_sda_lo_d = 1'h0;
               if (ph_q == 2'h1)
                  m_scl_lo_d = 1'h0;
               if (ph_q == 2'h2)
                  m_sda_lo_d = 1'h1; // RULE_05
               if (ph_q == PH_LAST) begin
                  m_scl_lo_d = 1'h1;
                  m_clr[1] = 1'h1; // RULE_05
               end
            end
            M_STOP: begin
               if (ph_q == 2'h0)
                  m_sda_lo_d = 1'h1;
               if (ph_q == 2'h1)
                  m_scl_lo_d = 1'h0;
               if (ph_q == 2'h2)
                  m_sda_lo_d = 1'h0; // RULE_04
               if (ph_q == PH_LAST) begin
                  m_clr[2] = 1'h1; // RULE_04
                  mown_d = 1'h0;
               end
            end
            M_TX, M_RX, M_ACK: begin
               if (ph_q == 2'h0) begin
                  if (m_st_q == M_TX)
                     m_sda_lo_d = (bit_q != BIT_ACK) & ~sh_q[7];
                  else if (m_st_q == M_RX)
                     m_sda_lo_d = 1'h0;
                  else
                     m_sda_lo_d = ~ctrl_q.ack_value; // RULE_01 RULE_02
               end
               if (ph_q == 2'h1)
                  m_scl_lo_d = 1'h0;
               if (ph_q == 2'h2 && m_st_q == M_RX)
                  sh_d = {sh_q[6:0], bus.sda};
               if (ph_q == 2'h2 && m_st_q == M_TX && bit_q == BIT_ACK)
                  m_ackv = 1'h1; // RULE_14
               if (ph_q == PH_LAST) begin
                  m_scl_lo_d = 1'h1;
                  bit_d = bit_q + 4'h1;
                  if (m_st_q == M_TX)
                     sh_d = {sh_q[6:0], 1'h0};
                  if (m_st_q == M_TX && bit_q == BIT_ACK)
                     m_txd = 1'h1; // RULE_13
                  if (m_st_q == M_RX && bit_q == BIT_LAST) begin
                     m_rxv = 1'h1;
                     m_clr[3] = 1'h1; // RULE_03
                  end
                  if (m_st_q == M_ACK)
                     m_clr[4] = 1'h1; // RULE_02
               end
            end
            default: m_st_d = M_IDLE;
         endcase
         m_done = (ph_q == PH_LAST) &&
            (m_st_q != M_TX || bit_q == BIT_ACK) &&
            (m_st_q != M_RX || bit_q == BIT_LAST);
         if (m_done)
            m_st_d = M_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         m_st_q <= M_IDLE;
         ph_q <= '0;
         bit_q <= '0;
         cnt_q <= '0;
         sh_q <= '0;
         m_scl_lo_q <= 1'h0;
         m_sda_lo_q <= 1'h0;
         mown_q <= 1'h0;
      end else begin
         m_st_q <= m_st_d;
         ph_q <= ph_d;
         bit_q <= bit_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         m_scl_lo_q <= m_scl_lo_d;
         m_sda_lo_q <= m_sda_lo_d;
         mown_q <= mown_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // slave: follows the peer's clock edges, only ever drives data
   always_comb begin
      s_st_d = s_st_q;
      s_cnt_d = s_cnt_q;
      s_sh_d = s_sh_q;
      s_sda_lo_d = s_sda_lo_q;
      s_match = 1'h0;
      s_rxv = 1'h0;
      s_ackv = 1'h0;
      case (s_st_q)
         S_IDLE: s_sda_lo_d = 1'h0;
         S_ADDR, S_RXD: begin
            if (bus.scl_rise) begin
               s_sh_d = {s_sh_q[6:0], bus.sda};
               s_cnt_d = s_cnt_q + 4'h1;
            end
            if (bus.scl_fall && s_cnt_q == BIT_ACK) begin
               s_cnt_d = '0;
               if (s_st_q == S_RXD || s_hit) begin
                  s_match = (s_st_q == S_ADDR);
                  s_rxv = (s_st_q == S_RXD);
                  s_sda_lo_d = 1'h1;
                  s_st_d = S_ACKO;
               end else
                  s_st_d = S_IDLE;
            end
         end
         S_ACKO: begin
            if (bus.scl_fall) begin
               s_st_d = stat_q.slave_read ? S_TXD : S_RXD;
               s_sda_lo_d = stat_q.slave_read & ~txb_q[7];
            end
         end
         S_TXD: begin
            if (bus.scl_rise)
               s_cnt_d = s_cnt_q + 4'h1;
            if (bus.scl_fall) begin
               if (s_cnt_q == BIT_ACK) begin
                  s_sda_lo_d = 1'h0;
                  s_st_d = S_ACKI;
               end else
                  s_sda_lo_d = ~txb_q[~s_cnt_q[2:0]];
            end
         end
         S_ACKI: begin
            if (bus.scl_rise)
               s_ackv = 1'h1; // RULE_14
            if (bus.scl_fall) begin
               s_cnt_d = '0;
               s_st_d = stat_q.ack_received_status ? S_IDLE : S_TXD;
               s_sda_lo_d = ~stat_q.ack_received_status & ~txb_q[7];
            end
         end
         default: s_st_d = S_IDLE;
      endcase
      if (bus.start && m_st_q == M_IDLE && !mown_q) begin
         s_st_d = S_ADDR;
         s_cnt_d = '0;
         s_sda_lo_d = 1'h0;
      end
      if (bus.stop) begin
         s_st_d = S_IDLE;
         s_sda_lo_d = 1'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_st_q <= S_IDLE;
         s_cnt_q <= '0;
         s_sh_q <= '0;
         s_sda_lo_q <= 1'h0;
      end else begin
         s_st_q <= s_st_d;
         s_cnt_q <= s_cnt_d;
         s_sh_q <= s_sh_d;
         s_sda_lo_q <= s_sda_lo_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   a_ack_level: // RULE_01
      assert property (m_st_q == M_ACK && ph_q == 2'h2
         |-> m_sda_lo_q == !ctrl_q.ack_value)
      else $error("ack slot level differs from ack value");
   a_ack_clear: // RULE_02
      assert property (m_st_q == M_ACK && tick && ph_q == PH_LAST
         |=> !ctrl_q.ack_seq_enable && m_st_q == M_IDLE)
      else $error("ack enable not cleared");
   a_recv_clear: // RULE_03
      assert property (m_st_q == M_RX && tick && ph_q == PH_LAST &&
         bit_q == BIT_LAST |=> !ctrl_q.receive_byte_enable &&
         stat_q.rx_full_flag)
      else $error("receive enable not cleared after byte");
   a_stop_clear: // RULE_04
      assert property (m_st_q == M_STOP && tick && ph_q == PH_LAST
         |=> !ctrl_q.stop_seq_enable && !mown_q && !sda_oe[*2])
      else $error("stop sequence end wrong");
   a_restart_clr: // RULE_05
      assert property (m_st_q == M_RESTART && tick && ph_q == PH_LAST
         |=> !ctrl_q.restart_seq_enable && scl_oe)
      else $error("restart enable not cleared");
   a_start_cond: // RULE_06
      assert property (m_st_q == M_START && ph_q == 2'h2
         |-> m_sda_lo_q && !m_scl_lo_q)
      else $error("start condition shape wrong");
   a_no_stretch: // RULE_07
      assert property (s_st_q != S_IDLE && !mown_q |-> !scl_oe)
      else $error("clock held low while acting as slave");
   a_stop_flag: // RULE_09
      assert property (bus.stop |=> stat_q.stop_seen && !stat_q.start_seen)
      else $error("stop flag not updated");
   a_rx_full: // RULE_12
      assert property (rxr && !m_rxv && !s_rxv |=> !stat_q.rx_full_flag)
      else $error("receive full not cleared by read");
   a_tx_full: // RULE_13
      assert property (txw |=> stat_q.tx_full_flag && stat_q.data_addr)
      else $error("transmit full not set by write");
   a_mask_zero: // RULE_16
      assert property (acc(rd, addr, MASK_IDX)
         |=> rdata[15:10] == 6'h00 && rdata[9:0] == amask_q)
      else $error("mask register upper bits not zero");
endmodule // tws_core

// ### sim/tws_peer.sv
// two-wire peer model: a bus master that addresses the block's slave side
module tws_peer (
   input wire logic scl, // resolved clock line
   input wire logic sda, // resolved data line
   output logic scl_oe, // high while pulling clock low
   output logic sda_oe // high while pulling data low
);
   timeunit 1ns;
   timeprecision 1ns;
   // lines start released; the pull-up then gives idle high
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // pins move at mid-cycle, away from the block's sampling edge
   task automatic to_mid();
      #(20 - ($time % 20));
   endtask
   // start, or repeated start when called with the clock held low
   task automatic cond_start();
      to_mid();
      sda_oe = 1'b0;
      #40 scl_oe = 1'b0;
      #80 sda_oe = 1'b1;
      #80 scl_oe = 1'b1;
   endtask
   // stop: data rises while the clock is high, then the bus is left idle
   task automatic cond_stop();
      to_mid();
      sda_oe = 1'b1;
      #40 scl_oe = 1'b0;
      #80 sda_oe = 1'b0;
      #80;
   endtask
   // one byte msb first; low phase is long since the block sees edges late
   task automatic put_byte(input logic [7:0] b, output logic ack);
      to_mid();
      for (int i = 7; i >= 0; i--) begin
         #40 sda_oe = ~b[i];
         #40 scl_oe = 1'b0;
         #80 scl_oe = 1'b1;
      end
      #40 sda_oe = 1'b0;
      #40 scl_oe = 1'b0;
      #40 ack = ~sda;
      #40 scl_oe = 1'b1;
   endtask
   // one byte from the slave msb first, then the given answer bit
   task automatic get_byte(input logic ack, output logic [7:0] b);
      to_mid();
      for (int i = 7; i >= 0; i--) begin
         #80 scl_oe = 1'b0;
         #40 b[i] = sda;
         #40 scl_oe = 1'b1;
      end
      #40 sda_oe = ack;
      #40 scl_oe = 1'b0;
      #80 scl_oe = 1'b1;
      #40 sda_oe = 1'b0;
   endtask
endmodule // tws_peer

// ### sim/tb_top.sv
// testbench: register map, slave traffic from the peer, master sequences
module tb_top
   import tws_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [3:0] a;
      logic [15:0] w;
      logic [15:0] e;
   } tws_row_type;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic irq, scl_oe, sda_oe, p_scl_oe, p_sda_oe, ack, slv_ph = 1'b0;
   logic [7:0] rbyte;
   wire logic scl = ~(scl_oe | p_scl_oe);
   wire logic sda = ~(sda_oe | p_sda_oe);
   int err_count = 0;
   int check_count = 0;
   // write then read back; status read-only, unmapped index reads zero
   tws_row_type rows [8] = '{'{STAT_IDX, 16'hFFFF, 16'h0000},
      '{MASK_IDX, 16'hFFFF, 16'h03FF}, '{MASK_IDX, 16'h0000, 16'h0000},
      '{BRG_IDX, 16'h0001, 16'h0001}, '{IMSK_IDX, 16'h0001, 16'h0001},
      '{4'hF, 16'hFFFF, 16'h0000}, '{CTRL_IDX, 16'h0020, 16'h0020},
      '{CTRL_IDX, 16'h0000, 16'h0000}};
   logic [15:0] rst_exp [9] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
      16'h0050, 16'h000F, 16'h0, 16'h0};
   tws_core dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .scl_in(scl),
      .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
      .sda_oe(sda_oe));
   tws_peer peer (.scl(scl), .sda(sda), .scl_oe(p_scl_oe),
      .sda_oe(p_sda_oe));
   // 50 MHz system clock
   initial begin
      forever #10 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] e, g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one-cycle strobes, changed just after the edge
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] m, e,
      input string nm);
      logic [15:0] v;
      rd_reg(a, v);
      check(nm, e, v & m);
   endtask
   // bounded poll until the masked bits read zero
   task automatic wait_clr(input logic [3:0] a, input logic [15:0] m);
      logic [15:0] v;
      for (int n = 0; n < 500; n++) begin
         rd_reg(a, v);
         if ((v & m) === 16'h0000) return;
      end
      err_count++;
      $display("mismatch wait_clr expected %h seen %h", 16'h0, v & m);
      close_out();
   endtask
   ////////////////////////////////////////////////////////////////////
   // the block must never hold the clock while acting as slave
   always @(negedge clk) begin
      if (slv_ph && scl_oe === 1'b1) begin
         check("slave scl_oe", 16'h0, 16'h1);
      end
   end
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].w);
         rd_chk(rows[i].a, 16'hFFFF, rows[i].e, "table");
      end
      // reset again in mid-run: every register back to its reset value
      @(posedge clk);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         rd_chk(i[3:0], 16'hFFFF, rst_exp[i], "reset value");
      end
      check("irq reset", 16'h0, {15'h0, irq});
      wr_reg(BRG_IDX, 16'h0001);
      wr_reg(IMSK_IDX, 16'h0001);
      wr_reg(CTRL_IDX, 16'h8000);
      // slave write: own address, then a data byte
      slv_ph = 1'b1;
      peer.cond_start();
      peer.put_byte(8'hA0, ack);
      check("addr ack", 16'h1, {15'h0, ack});
      rd_chk(STAT_IDX, 16'h003F, 16'h0008, "status addr");
      peer.put_byte(8'h5A, ack);
      check("data ack", 16'h1, {15'h0, ack});
      rd_chk(STAT_IDX, 16'h003F, 16'h002A, "status data");
      rd_chk(RXB_IDX, 16'hFFFF, 16'h005A, "rx byte");
      rd_chk(STAT_IDX, 16'h003F, 16'h0028, "rx read");
      // other address refused, then accepted once its bit is masked
      peer.cond_start();
      peer.put_byte(8'hA2, ack);
      check("nomask ack", 16'h0, {15'h0, ack});
      wr_reg(MASK_IDX, 16'h0001);
      peer.cond_start();
      peer.put_byte(8'hA2, ack);
      check("mask ack", 16'h1, {15'h0, ack});
      rd_chk(STAT_IDX, 16'h003F, 16'h0008, "status restart");
      // slave read: the peer fetches the transmit buffer and acks it
      wr_reg(TXB_IDX, 16'h00C3);
      peer.cond_start();
      peer.put_byte(8'hA1, ack);
      peer.get_byte(1'b1, rbyte);
      check("slave tx", 16'h00C3, {8'h00, rbyte});
      rd_chk(STAT_IDX, 16'h803F, 16'h000C, "slave read");
      peer.cond_stop();
      slv_ph = 1'b0;
      rd_chk(STAT_IDX, 16'h0018, 16'h0010, "status stop");
      rd_chk(IFL_IDX, 16'h0006, 16'h0006, "int flags");
      check("irq masked", 16'h0, {15'h0, irq});
      wr_reg(IFL_IDX, 16'h0007);
      rd_chk(IFL_IDX, 16'hFFFF, 16'h0000, "int clear");
      // master: one sequence at a time, each waited out
      wr_reg(CTRL_IDX, 16'h8001);
      wait_clr(CTRL_IDX, 16'h0001);
      check("irq start", 16'h1, {15'h0, irq});
      check("sda start", 16'h0, {15'h0, sda});
      wr_reg(TXB_IDX, 16'h00A5);
      rd_chk(STAT_IDX, 16'h0021, 16'h0021, "tx full");
      wait_clr(STAT_IDX, 16'h0001);
      rd_chk(STAT_IDX, 16'h8000, 16'h8000, "nack seen");
      wr_reg(CTRL_IDX, 16'h8008);
      wait_clr(CTRL_IDX, 16'h0008);
      rd_chk(RXB_IDX, 16'hFFFF, 16'h00FF, "master rx");
      wr_reg(CTRL_IDX, 16'h8030);
      wait_clr(CTRL_IDX, 16'h0010);
      rd_chk(CTRL_IDX, 16'h003F, 16'h0020, "ack done");
      wr_reg(CTRL_IDX, 16'h8010);
      wait_clr(CTRL_IDX, 16'h0010);
      wr_reg(CTRL_IDX, 16'h8002);
      wait_clr(CTRL_IDX, 16'h0002);
      wr_reg(CTRL_IDX, 16'h8004);
      wait_clr(CTRL_IDX, 16'h0004);
      check("bus idle", 16'h3, {14'h0, scl, sda});
      rd_chk(STAT_IDX, 16'h0018, 16'h0010, "master stop");
      close_out();
   end
endmodule // tb_top
